// ---- logic/pmc_power_mode_controller.sv ----
// power mode controller: mode state machine and per-mode enables
// assumes all inputs are synchronous to clk; analog flags are levels
`default_nettype none
module pmc_power_mode_controller #(
   parameter int RESET_DELAY_CYCLES = pmc_pkg::RESET_DELAY_CYC,
   parameter int UV_FILTER_CYCLES = pmc_pkg::UV_FILTER_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_mode,
   input wire logic cmd_aux_on,
   input wire logic cfg_aux_standby_on,
   input wire logic cfg_aux_run_off,
   input wire logic cfg_converter_sleep_on,
   input wire logic io_supply_uv,
   input wire logic overtemp_warn,
   input wire logic overtemp_shut,
   input wire logic temp_recovered,
   input wire logic bus_wake,
   input wire logic local_wake,
   input wire logic startup_wd_ok,
   input wire logic startup_wd_miss,
   output logic [2:0] mode,
   output logic reset_out_n,
   output logic converter_en,
   output logic io_supply_regulator_en,
   output logic aux_regulator_a_en,
   output logic aux_regulator_b_en,
   output logic bus_tx_en,
   output logic bus_rx_en,
   output logic wake_rx_en,
   output logic local_wake_en,
   output logic overtemp_monitor_en,
   output logic window_watchdog_en,
   output logic host_if_en,
   output logic reset_unit_en,
   output logic bus_recessive
);
   localparam int CW = 23;
   localparam logic [CW-1:0] RES_LAST = CW'(RESET_DELAY_CYCLES - 1);
   localparam logic [CW-1:0] FLT_LAST = CW'(UV_FILTER_CYCLES - 1);
   localparam logic [1:0] MISS_LAST = 2'(pmc_pkg::STARTUP_MISS_MAX - 1);

   pmc_pkg::pmc_state_t state_r, state_nxt;
   logic [CW-1:0] res_cnt_r, res_cnt_nxt;
   logic [CW-1:0] flt_cnt_r, flt_cnt_nxt;
   logic uv_filt_r, uv_filt_nxt;
   logic rst_done_r, rst_done_nxt;
   logic [1:0] miss_r, miss_nxt;
   logic thermal_sleep_r, thermal_sleep_nxt;
   logic aux_cmd_r, aux_cmd_nxt;
   logic tx_block_r, tx_block_nxt;
   logic [13:0] out_nxt;
   logic [13:0] out_r;
   logic cmd_ok;
   logic wake_any;

   assign cmd_ok = cmd_valid && (state_r == pmc_pkg::PMC_NORMAL ||
      state_r == pmc_pkg::PMC_RXONLY || state_r == pmc_pkg::PMC_STANDBY);
   assign wake_any = bus_wake || local_wake;

   always_comb begin
      flt_cnt_nxt = flt_cnt_r;
      uv_filt_nxt = uv_filt_r;
      if (io_supply_uv == uv_filt_r) begin
         flt_cnt_nxt = '0;
      end else if (flt_cnt_r == FLT_LAST) begin
         flt_cnt_nxt = '0;
         uv_filt_nxt = io_supply_uv;
      end else begin
         flt_cnt_nxt = flt_cnt_r + CW'(1);
      end
   end

   always_comb begin
      state_nxt = state_r;
      res_cnt_nxt = res_cnt_r;
      rst_done_nxt = rst_done_r;
      miss_nxt = miss_r;
      thermal_sleep_nxt = thermal_sleep_r;
      aux_cmd_nxt = aux_cmd_r;
      tx_block_nxt = tx_block_r;
      if (cmd_ok) begin
         aux_cmd_nxt = cmd_aux_on;
      end
      if (overtemp_warn) begin
         tx_block_nxt = 1'b1;
      end else if (temp_recovered) begin
         tx_block_nxt = 1'b0;
      end
      unique case (state_r)
         pmc_pkg::PMC_POWERUP: begin
            if (uv_filt_r) begin
               res_cnt_nxt = '0;
               rst_done_nxt = 1'b0;
            end else if (!rst_done_r) begin
               if (res_cnt_r == RES_LAST) begin
                  rst_done_nxt = 1'b1;
                  res_cnt_nxt = '0;
               end else begin
                  res_cnt_nxt = res_cnt_r + CW'(1);
               end
            end else if (startup_wd_ok) begin
               state_nxt = pmc_pkg::PMC_STANDBY;
               miss_nxt = pmc_pkg::MISS_W0;
               aux_cmd_nxt = 1'b0;
            end else if (startup_wd_miss) begin
               rst_done_nxt = 1'b0;
               if (miss_r == MISS_LAST) begin
                  state_nxt = pmc_pkg::PMC_SLEEP;
                  miss_nxt = pmc_pkg::MISS_W0;
                  thermal_sleep_nxt = 1'b0;
               end else begin
                  miss_nxt = miss_r + 2'h1;
               end
            end
         end
         pmc_pkg::PMC_SLEEP: begin
            if (wake_any && (!thermal_sleep_r || temp_recovered)) begin
               state_nxt = pmc_pkg::PMC_POWERUP;
               rst_done_nxt = 1'b0;
               res_cnt_nxt = '0;
               thermal_sleep_nxt = 1'b0;
            end
         end
         default: begin
            if (cmd_ok) begin
               unique case (pmc_pkg::pmc_cmd_t'(cmd_mode))
                  pmc_pkg::PMC_CMD_NORMAL: state_nxt = pmc_pkg::PMC_NORMAL;
                  pmc_pkg::PMC_CMD_RXONLY: state_nxt = pmc_pkg::PMC_RXONLY;
                  pmc_pkg::PMC_CMD_STANDBY: state_nxt = pmc_pkg::PMC_STANDBY;
                  pmc_pkg::PMC_CMD_SLEEP: state_nxt = pmc_pkg::PMC_SLEEP;
               endcase
            end
         end
      endcase
      if (state_r != pmc_pkg::PMC_SLEEP && overtemp_shut) begin
         state_nxt = pmc_pkg::PMC_SLEEP;
         thermal_sleep_nxt = 1'b1;
      end else if (state_r != pmc_pkg::PMC_SLEEP && state_r != pmc_pkg::PMC_POWERUP &&
            uv_filt_r) begin
         state_nxt = pmc_pkg::PMC_POWERUP;
         rst_done_nxt = 1'b0;
         res_cnt_nxt = '0;
      end
   end

   // per-mode enables from the next state so outputs come from flops, except converter_en, which also ORs in ~reset_n
   always_comb begin
      logic run;
      logic low;
      logic slp;
      run = state_nxt == pmc_pkg::PMC_NORMAL || state_nxt == pmc_pkg::PMC_RXONLY;
      low = state_nxt == pmc_pkg::PMC_STANDBY;
      slp = state_nxt == pmc_pkg::PMC_SLEEP;
      out_nxt[0] = !slp || cfg_converter_sleep_on;
      out_nxt[1] = !slp;
      out_nxt[2] = (run && !cfg_aux_run_off) || (low && (cfg_aux_standby_on || aux_cmd_nxt));
      out_nxt[3] = out_nxt[2];
      out_nxt[4] = state_nxt == pmc_pkg::PMC_NORMAL && !tx_block_nxt;
      out_nxt[5] = run;
      out_nxt[6] = low || slp;
      out_nxt[7] = low || slp;
      out_nxt[8] = 1'b1;
      out_nxt[9] = run || low;
      out_nxt[10] = run || low;
      out_nxt[11] = !slp;
      out_nxt[12] = slp || low || state_nxt == pmc_pkg::PMC_POWERUP;
      out_nxt[13] = state_nxt != pmc_pkg::PMC_POWERUP || rst_done_nxt;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= pmc_pkg::PMC_POWERUP;
         res_cnt_r <= '0;
         flt_cnt_r <= '0;
         uv_filt_r <= 1'b0;
         rst_done_r <= 1'b0;
         miss_r <= pmc_pkg::MISS_W0;
         thermal_sleep_r <= 1'b0;
         aux_cmd_r <= 1'b0;
         tx_block_r <= 1'b0;
         out_r <= 14'h0102;
      end else begin
         state_r <= state_nxt;
         res_cnt_r <= res_cnt_nxt;
         flt_cnt_r <= flt_cnt_nxt;
         uv_filt_r <= uv_filt_nxt;
         rst_done_r <= rst_done_nxt;
         miss_r <= miss_nxt;
         thermal_sleep_r <= thermal_sleep_nxt;
         aux_cmd_r <= aux_cmd_nxt;
         tx_block_r <= tx_block_nxt;
         out_r <= out_nxt;
      end
   end

   assign mode = state_r;
   assign converter_en = out_r[0] | ~reset_n;
   assign io_supply_regulator_en = out_r[1];
   assign aux_regulator_a_en = out_r[2];
   assign aux_regulator_b_en = out_r[3];
   assign bus_tx_en = out_r[4];
   assign bus_rx_en = out_r[5];
   assign wake_rx_en = out_r[6];
   assign local_wake_en = out_r[7];
   assign overtemp_monitor_en = out_r[8];
   assign window_watchdog_en = out_r[9];
   assign host_if_en = out_r[10];
   assign reset_unit_en = out_r[11];
   assign bus_recessive = out_r[12];
   assign reset_out_n = out_r[13];

   sequence s_in_sleep;
      state_r == pmc_pkg::PMC_SLEEP;
   endsequence
   a_sleep_no_wake: assert property (@(posedge clk) disable iff (!reset_n)
      state_r == pmc_pkg::PMC_SLEEP && !bus_wake && !local_wake && !overtemp_shut
      |=> s_in_sleep)
      else $error("sleep left without wake");
   a_thermal_sleep_hold: assert property (@(posedge clk) disable iff (!reset_n)
      state_r == pmc_pkg::PMC_SLEEP && thermal_sleep_r && !temp_recovered |=> s_in_sleep)
      else $error("thermal sleep left while hot");
   a_shut_to_sleep: assert property (@(posedge clk) disable iff (!reset_n)
      overtemp_shut |=> s_in_sleep)
      else $error("shutdown did not enter sleep");
   a_sleep_outputs: assert property (@(posedge clk) disable iff (!reset_n)
      s_in_sleep |-> !io_supply_regulator_en && !bus_tx_en && !window_watchdog_en
      && bus_recessive && !reset_unit_en)
      else $error("sleep enables wrong");
   a_rxonly_tx_off: assert property (@(posedge clk) disable iff (!reset_n)
      state_r == pmc_pkg::PMC_RXONLY |-> !bus_tx_en && bus_rx_en && io_supply_regulator_en)
      else $error("receive-only enables wrong");
   a_standby_out: assert property (@(posedge clk) disable iff (!reset_n)
      state_r == pmc_pkg::PMC_STANDBY |-> !bus_tx_en && !bus_rx_en && wake_rx_en
      && io_supply_regulator_en)
      else $error("standby enables wrong");
   a_cmd_ignored: assert property (@(posedge clk) disable iff (!reset_n)
      state_r == pmc_pkg::PMC_POWERUP && !startup_wd_ok && !startup_wd_miss && !overtemp_shut
      |=> state_r != pmc_pkg::PMC_NORMAL)
      else $error("command taken in power-up");
   a_uv_filter: assert property (@(posedge clk) disable iff (!reset_n)
      !uv_filt_r && io_supply_uv ##1 !io_supply_uv |=> !uv_filt_r)
      else $error("one-cycle spike passed filter");
   a_warn_tx_off: assert property (@(posedge clk) disable iff (!reset_n)
      overtemp_warn |=> !bus_tx_en)
      else $error("transmitter on during warning");
   sequence s_boot_ready;
      state_r == pmc_pkg::PMC_POWERUP && rst_done_r && !uv_filt_r;
   endsequence
   a_boot_standby: assert property (@(posedge clk) disable iff (!reset_n)
      s_boot_ready ##0 (startup_wd_ok && !overtemp_shut) |=> state_r == pmc_pkg::PMC_STANDBY)
      else $error("ready power-up did not enter standby");
   a_miss_sleep: assert property (@(posedge clk) disable iff (!reset_n)
      s_boot_ready ##0 (!startup_wd_ok && startup_wd_miss && miss_r == MISS_LAST
      && !overtemp_shut) |=> s_in_sleep)
      else $error("last missed service did not enter sleep");
   a_uv_powerup: assert property (@(posedge clk) disable iff (!reset_n)
      uv_filt_r && !overtemp_shut && state_r != pmc_pkg::PMC_SLEEP
      && state_r != pmc_pkg::PMC_POWERUP |=> state_r == pmc_pkg::PMC_POWERUP && !reset_out_n)
      else $error("undervoltage did not return to power-up");
   a_cmd_normal: assert property (@(posedge clk) disable iff (!reset_n)
      cmd_valid && cmd_mode == pmc_pkg::PMC_CMD_NORMAL && state_r == pmc_pkg::PMC_STANDBY
      && !uv_filt_r && !overtemp_shut |=> state_r == pmc_pkg::PMC_NORMAL)
      else $error("normal command not taken in standby");
   a_normal_out: assert property (@(posedge clk) disable iff (!reset_n)
      state_r == pmc_pkg::PMC_NORMAL |-> converter_en && io_supply_regulator_en && bus_rx_en
      && window_watchdog_en && host_if_en)
      else $error("normal enables wrong");
   a_wake_gate: assert property (@(posedge clk) disable iff (!reset_n)
      wake_rx_en || local_wake_en |-> state_r == pmc_pkg::PMC_STANDBY
      || state_r == pmc_pkg::PMC_SLEEP)
      else $error("wake detection on outside standby and sleep");
   a_host_gate: assert property (@(posedge clk) disable iff (!reset_n)
      host_if_en || window_watchdog_en |-> state_r == pmc_pkg::PMC_NORMAL
      || state_r == pmc_pkg::PMC_RXONLY || state_r == pmc_pkg::PMC_STANDBY)
      else $error("host interface on outside its modes");
endmodule
`default_nettype wire

// ---- logic/pmc_pkg.sv ----
// package for the power mode controller: states and timing constants
// assumes a 50 MHz always-on clock
`default_nettype none
package pmc_pkg;
   localparam int CLK_MHZ = 50;
   // spike filter on the io supply undervoltage flag, least time in us
   localparam int UV_FILTER_US = 2;
   localparam int UV_FILTER_CYC = UV_FILTER_US * CLK_MHZ;
   // reset delay time, least time in ms
   localparam int RESET_DELAY_MS = 4;
   localparam int RESET_DELAY_CYC = RESET_DELAY_MS * 1000 * CLK_MHZ;
   localparam int STARTUP_MISS_MAX = 3;
   localparam logic [1:0] MISS_W0 = 2'h0;
   typedef enum logic [2:0] {
      PMC_POWERUP = 3'h0,
      PMC_NORMAL = 3'h1,
      PMC_RXONLY = 3'h2,
      PMC_STANDBY = 3'h3,
      PMC_SLEEP = 3'h4
   } pmc_state_t;
   typedef enum logic [1:0] {
      PMC_CMD_NORMAL = 2'h0,
      PMC_CMD_RXONLY = 2'h1,
      PMC_CMD_STANDBY = 2'h2,
      PMC_CMD_SLEEP = 2'h3
   } pmc_cmd_t;
endpackage
`default_nettype wire

// ---- tb/pmc_host_model.sv ----
// host model: issues mode commands and services the startup watchdog
// assumes the controller samples its inputs on the rising edge of clk
`default_nettype none
module pmc_host_model (
   input wire logic clk,
   input wire logic reset_out_n,
   output var logic cmd_valid,
   output var logic [1:0] cmd_mode,
   output var logic cmd_aux_on,
   output var logic startup_wd_ok,
   output var logic startup_wd_miss
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cmd_valid = 1'b0;
      cmd_mode = 2'h0;
      cmd_aux_on = 1'b0;
      startup_wd_ok = 1'b0;
      startup_wd_miss = 1'b0;
   end
   task automatic send(input logic [1:0] m, input logic aux);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_mode = m;
      cmd_aux_on = aux;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_mode = ~m;
   endtask
   task automatic service(input logic ok);
      int n;
      n = 0;
      @(negedge clk);
      while (reset_out_n !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      startup_wd_ok = ok;
      startup_wd_miss = !ok;
      @(negedge clk);
      startup_wd_ok = 1'b0;
      startup_wd_miss = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// testbench for the power mode controller
// assumes the host model drives commands and startup watchdog pulses
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset_n;
   logic cfg_sb, cfg_off, cfg_cs, uv, warn;
   logic shut, recov, bwake, lwake;
   logic cmdv, cmda, wok, wms;
   logic [1:0] cmdm;
   logic cv, io, la, lb, tx, rx, wk, lw, ot, wd, hi, ru, br, ron;
   logic [2:0] mode;
   wire logic [10:0] en = {cv, io, la, lb, tx, rx, wk, lw, ot, wd, hi};
   int checked = 0;
   int miscompares = 0;
   pmc_host_model u_host (.clk(clk), .reset_out_n(ron), .cmd_valid(cmdv), .cmd_mode(cmdm),
      .cmd_aux_on(cmda), .startup_wd_ok(wok), .startup_wd_miss(wms));
   pmc_power_mode_controller #(.RESET_DELAY_CYCLES(20), .UV_FILTER_CYCLES(4)) u_dut (
      .clk(clk), .reset_n(reset_n), .cmd_valid(cmdv), .cmd_mode(cmdm), .cmd_aux_on(cmda),
      .cfg_aux_standby_on(cfg_sb), .cfg_aux_run_off(cfg_off), .cfg_converter_sleep_on(cfg_cs),
      .io_supply_uv(uv), .overtemp_warn(warn), .overtemp_shut(shut), .temp_recovered(recov),
      .bus_wake(bwake), .local_wake(lwake), .startup_wd_ok(wok), .startup_wd_miss(wms),
      .mode(mode), .reset_out_n(ron), .converter_en(cv), .io_supply_regulator_en(io),
      .aux_regulator_a_en(la), .aux_regulator_b_en(lb), .bus_tx_en(tx), .bus_rx_en(rx),
      .wake_rx_en(wk), .local_wake_en(lw), .overtemp_monitor_en(ot),
      .window_watchdog_en(wd), .host_if_en(hi), .reset_unit_en(ru), .bus_recessive(br));
   always #10 clk = ~clk;
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic t_boot;
      u_host.service(1'b1);
      chk({8'h00, mode}, 11'h003);
      chk(en, 11'h61F);
      $display("test boot done");
   endtask
   task automatic t_modes;
      u_host.send(pmc_pkg::PMC_CMD_NORMAL, 1'b0);
      chk(en, 11'h7E7);
      chk({9'h000, ru, br}, 11'h002);
      cfg_off = 1'b1;
      cyc(2);
      chk(en, 11'h667);
      cfg_off = 1'b0;
      u_host.send(pmc_pkg::PMC_CMD_RXONLY, 1'b0);
      chk({8'h00, mode}, 11'h002);
      chk(en, 11'h7A7);
      u_host.send(pmc_pkg::PMC_CMD_STANDBY, 1'b0);
      chk(en, 11'h61F);
      cfg_sb = 1'b1;
      cyc(2);
      chk(en, 11'h79F);
      cfg_sb = 1'b0;
      u_host.send(pmc_pkg::PMC_CMD_STANDBY, 1'b1);
      chk(en, 11'h79F);
      u_host.send(pmc_pkg::PMC_CMD_STANDBY, 1'b0);
      chk(en, 11'h61F);
      cyc(2);
      $display("test modes done");
   endtask
   task automatic t_warn;
      u_host.send(pmc_pkg::PMC_CMD_NORMAL, 1'b0);
      warn = 1'b1;
      cyc(2);
      chk(en, 11'h7A7);
      chk({8'h00, mode}, 11'h001);
      warn = 1'b0;
      recov = 1'b1;
      cyc(2);
      chk(en, 11'h7E7);
      recov = 1'b0;
      u_host.send(pmc_pkg::PMC_CMD_STANDBY, 1'b0);
      $display("test warn done");
   endtask
   task automatic t_uv;
      uv = 1'b1;
      cyc(1);
      uv = 1'b0;
      cyc(1);
      uv = 1'b1;
      cyc(3);
      uv = 1'b0;
      cyc(6);
      chk({8'h00, mode}, 11'h003);
      uv = 1'b1;
      cyc(8);
      chk({7'h00, ron, mode}, 11'h000);
      chk(en, 11'h604);
      uv = 1'b0;
      t_boot;
      $display("test uv done");
   endtask
   task automatic t_sleep;
      u_host.send(pmc_pkg::PMC_CMD_SLEEP, 1'b0);
      chk({8'h00, mode}, 11'h004);
      chk(en, 11'h01C);
      chk({9'h000, ru, br}, 11'h001);
      u_host.send(pmc_pkg::PMC_CMD_NORMAL, 1'b0);
      chk({8'h00, mode}, 11'h004);
      lwake = 1'b1;
      cyc(2);
      chk({8'h00, mode}, 11'h000);
      lwake = 1'b0;
      t_boot;
      $display("test sleep done");
   endtask
   task automatic t_thermal;
      cfg_cs = 1'b1;
      shut = 1'b1;
      cyc(2);
      chk({7'h00, cv, mode}, 11'h00C);
      shut = 1'b0;
      bwake = 1'b1;
      cyc(4);
      chk({8'h00, mode}, 11'h004);
      recov = 1'b1;
      cyc(2);
      chk({8'h00, mode}, 11'h000);
      bwake = 1'b0;
      recov = 1'b0;
      cfg_cs = 1'b0;
      $display("test thermal done");
   endtask
   task automatic t_miss;
      u_host.service(1'b0);
      u_host.service(1'b0);
      chk({8'h00, mode}, 11'h000);
      u_host.service(1'b0);
      cyc(2);
      chk({8'h00, mode}, 11'h004);
      $display("test miss done");
   endtask
   task automatic wrap_up;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      wrap_up;
   end
   initial begin
      reset_n = 1'b0;
      {cfg_sb, cfg_off, cfg_cs, uv, warn} = 5'h00;
      {shut, recov, bwake, lwake} = 4'h0;
      cyc(4);
      reset_n = 1'b1;
      t_boot;
      t_modes;
      t_warn;
      t_uv;
      t_sleep;
      t_thermal;
      t_miss;
      wrap_up;
   end
endmodule
`default_nettype wire
